// >>> logic/guard_pkg.sv
// Constants for the timeout guard block
package guard_pkg;
  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [7:0] reset_cause_addr   = 8'ha1;
  localparam logic [7:0] guard_control_addr = 8'hb6;
  localparam logic [7:0] guard_refresh_addr = 8'hb7;
  localparam logic [7:0] timed_access_addr  = 8'hf7;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int         enable_bit_pos    = 5;
  localparam int         guard_flag_pos    = 3;
  localparam logic [7:0] control_reset_val = 8'h04;
  localparam logic [3:0] divider_reset_val = 4'h4;
  localparam logic [7:0] control_write_mask = 8'h2f;
  // ----------------------------------------
  // Key values
  // ----------------------------------------
  localparam logic [7:0] refresh_key_val = 8'h55;
  localparam logic [7:0] unlock_key_one  = 8'h55;
  localparam logic [7:0] unlock_key_two  = 8'haa;
  localparam logic [7:0] unlock_key_three = 8'h5a;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int rc_freq_khz    = 250;
  localparam int counter_width  = 8;
  localparam int prescale_width = 15;
  // Unlock sequence states
  typedef enum logic [1:0] {key_idle, key_got_one, key_got_two, key_open} key_state_type;
endpackage : guard_pkg

// >>> logic/timeout_guard.sv
// Watchdog counter with timed-access control and reset-cause flag
//
// Overview of operation
// - 8-bit up-counter, overflow requests chip reset
// - External reset disables guard, clears registers
// - Runs on RC clock tick, also during sleep
// - Enabled timeout resets chip in any mode
// - Divider two to select power, 256-period timeout
// - Divider field resets to 0100b
// - Inhibit option sampled at reset forces disable
// - Enable with inhibit clear starts counting
// - Every reset clears the enable bit
// - Software cannot stop a started counter
// - Writing 0x55 to refresh register clears counter
// - Overflow sets guard flag bit 3, resets
// - Flag cleared by software, external, power-on
// - Control writable only after 55,aa,5a sequence
// - Enable bit 5, divider bits 3:0, reset 04
`timescale 1ns/1ps
module timeout_guard (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ext_reset,
  input  wire logic       por_reset,
  input  wire logic       rc_clk,
  input  wire logic       guard_inhibit_option,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  output logic            chip_reset_req
);
  import guard_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [2:0]                rc_sync;     // RC clock sampler, bit0 is first stage
    logic [prescale_width-1:0] prescale;    // Divider chain on RC ticks
    logic [counter_width-1:0]  count;       // Guard counter
    logic                      running;     // Counter has started
    logic                      enable;      // Enable bit
    logic [3:0]                divider;     // Divider select
    logic                      inhibit;     // Inhibit option caught at reset
    logic                      guard_flag;  // Guard reset flag
    key_state_type             key_state;   // Unlock progress
    logic [7:0]                rdata;       // Read data
    logic                      reset_req;   // Reset request out
  } state_type;

  state_type cur_ff;  // Registered state
  state_type nxt_ff;  // Next state

  // ----------------------------------------
  // Internal strobes
  // ----------------------------------------
  logic rc_tick;      // One tick per RC rising edge
  logic div_tick;     // One tick per divided clock period
  logic wr_control;   // Control register write accepted

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Divided clock tick: all lower prescale bits at one on an RC tick
  function automatic logic div_done(input logic [prescale_width-1:0] pre,
                                    input logic [3:0] sel);
    logic [prescale_width-1:0] mask;
    mask = (prescale_width'(1) << sel) - prescale_width'(1);
    return (pre & mask) == mask;
  endfunction : div_done

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    nxt_ff = cur_ff;
    // Only second and third stages are examined
    nxt_ff.rc_sync = {cur_ff.rc_sync[1:0], rc_clk};
    rc_tick = cur_ff.rc_sync[1] & ~cur_ff.rc_sync[2];
    div_tick = rc_tick & div_done(cur_ff.prescale, cur_ff.divider);
    wr_control = sfr_wr && sfr_addr == guard_control_addr && cur_ff.key_state == key_open;
    nxt_ff.reset_req = 1'b0;

    // ----------------------------------------
    // Prescaler and guard counter
    // ----------------------------------------
    // Prescaler runs freely on the RC tick
    if (rc_tick) begin
      nxt_ff.prescale = cur_ff.prescale + prescale_width'(1);
    end
    // Counter start once enabled and not inhibited
    if (cur_ff.enable && !cur_ff.inhibit) begin
      nxt_ff.running = 1'b1;
    end
    if (cur_ff.running && div_tick) begin
      nxt_ff.count = cur_ff.count + counter_width'(1);
      if (&cur_ff.count) begin
        nxt_ff.guard_flag = 1'b1;
        nxt_ff.reset_req = 1'b1;
      end
    end

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    // Timed-access unlock sequence
    if (sfr_wr && sfr_addr == timed_access_addr) begin
      case (cur_ff.key_state)
        // Waiting for the first key
        key_idle: begin
          nxt_ff.key_state = (sfr_wdata == unlock_key_one) ? key_got_one : key_idle;
        end
        // First key seen, second expected
        key_got_one: begin
          nxt_ff.key_state = (sfr_wdata == unlock_key_two) ? key_got_two : key_idle;
        end
        // Second key seen, last expected
        key_got_two: begin
          nxt_ff.key_state = (sfr_wdata == unlock_key_three) ? key_open : key_idle;
        end
        // Open lock: a new first key restarts the sequence
        default: begin
          nxt_ff.key_state = (sfr_wdata == unlock_key_one) ? key_got_one : key_idle;
        end
      endcase
    end
    // Control write closes the lock again
    if (wr_control) begin
      nxt_ff.enable = sfr_wdata[enable_bit_pos];
      nxt_ff.divider = sfr_wdata[3:0];
      nxt_ff.key_state = key_idle;
    end
    // Refresh key clears the counter
    if (sfr_wr && sfr_addr == guard_refresh_addr && sfr_wdata == refresh_key_val) begin
      nxt_ff.count = '0;
    end
    // Software clears the flag by writing zero to bit 3; overflow set wins
    if (sfr_wr && sfr_addr == reset_cause_addr && !sfr_wdata[guard_flag_pos]
        && !nxt_ff.reset_req) begin
      nxt_ff.guard_flag = 1'b0;
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Read mux
    case (sfr_addr)
      guard_control_addr: nxt_ff.rdata = {2'b00, cur_ff.enable, 1'b0, cur_ff.divider};
      reset_cause_addr:   nxt_ff.rdata = 8'(cur_ff.guard_flag) << guard_flag_pos;
      default:            nxt_ff.rdata = 8'h00;
    endcase
    if (!sfr_rd) begin
      nxt_ff.rdata = 8'h00;
    end

    // ----------------------------------------
    // Chip resets
    // ----------------------------------------
    // Any reset of the chip ends counting and clears enable
    if (cur_ff.reset_req || ext_reset || por_reset) begin
      nxt_ff.enable = 1'b0;
      nxt_ff.running = 1'b0;
      nxt_ff.count = '0;
      nxt_ff.divider = divider_reset_val;
      nxt_ff.key_state = key_idle;
      nxt_ff.inhibit = guard_inhibit_option;
    end
    if (ext_reset || por_reset) begin
      nxt_ff.guard_flag = 1'b0;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      cur_ff <= '{rc_sync: 3'h0, prescale: '0, count: '0, running: 1'b0, enable: 1'b0,
                  divider: divider_reset_val, inhibit: 1'b1, guard_flag: 1'b0,
                  key_state: key_idle, rdata: 8'h00, reset_req: 1'b0};
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Both outputs come straight from the state register
  assign sfr_rdata = cur_ff.rdata;
  assign chip_reset_req = cur_ff.reset_req;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_overflow_resets: assert property (@(posedge mclk) disable iff (rst)
    (cur_ff.running && div_tick && &cur_ff.count && !ext_reset && !por_reset)
      |=> chip_reset_req && cur_ff.guard_flag) else $error("overflow lost");
  a_inhibit_blocks: assert property (@(posedge mclk) disable iff (rst)
    cur_ff.inhibit |-> !cur_ff.running) else $error("inhibited guard runs");
  a_refresh_clears: assert property (@(posedge mclk) disable iff (rst)
    (sfr_wr && sfr_addr == guard_refresh_addr && sfr_wdata == refresh_key_val)
      |=> cur_ff.count == '0) else $error("refresh missed");
  a_no_stop: assert property (@(posedge mclk) disable iff (rst)
    (cur_ff.running && !chip_reset_req && !ext_reset && !por_reset) |=> cur_ff.running)
    else $error("guard stopped");
  a_locked_write: assert property (@(posedge mclk) disable iff (rst)
    (sfr_wr && sfr_addr == guard_control_addr && cur_ff.key_state != key_open
     && !ext_reset && !por_reset && !chip_reset_req)
      |=> $stable(cur_ff.enable) && $stable(cur_ff.divider)) else $error("locked write");
  a_reset_clears_en: assert property (@(posedge mclk) disable iff (rst)
    chip_reset_req |=> !cur_ff.enable && !cur_ff.running) else $error("enable kept");
  a_flag_kept: assert property (@(posedge mclk) disable iff (rst)
    (cur_ff.guard_flag && !sfr_wr && !ext_reset && !por_reset) |=> cur_ff.guard_flag)
    else $error("flag lost");
  a_divider_reset: assert property (@(posedge mclk) disable iff (rst)
    (ext_reset || por_reset) |=> cur_ff.divider == divider_reset_val)
    else $error("divider not reset");
  a_count_step: assert property (@(posedge mclk) disable iff (rst)
    (!div_tick && !ext_reset && !por_reset && !chip_reset_req) |=> $stable(cur_ff.count)
      || cur_ff.count == '0) else $error("count moved");
  c_unlock: cover property (@(posedge mclk) cur_ff.key_state == key_open);
  c_timeout: cover property (@(posedge mclk) chip_reset_req);
  c_refresh: cover property (@(posedge mclk) cur_ff.running && sfr_wr
    && sfr_addr == guard_refresh_addr);
  // Guard inhibited although software set the enable bit
  c_inhibit_hold: cover property (@(posedge mclk) cur_ff.inhibit && cur_ff.enable);
  // Software writes the cause register while a flag left by a guard timeout is set
  c_soft_clear: cover property (@(posedge mclk) cur_ff.guard_flag && sfr_wr
    && sfr_addr == reset_cause_addr);

  // ----------------------------------------
  // Further checks on flags, access and sampling
  // ----------------------------------------

  // Software write of zero to the flag bit clears it
  // unless an overflow sets it in the same cycle
  a_flag_soft_clear: assert property (@(posedge mclk) disable iff (rst)
    (sfr_wr && sfr_addr == reset_cause_addr && !sfr_wdata[guard_flag_pos]
     && !(cur_ff.running && div_tick && &cur_ff.count)) |=> !cur_ff.guard_flag)
    else $error("flag not cleared by software");

  // External and power-on resets leave the flag clear
  // whatever happened in the same cycle
  a_flag_hw_clear: assert property (@(posedge mclk) disable iff (rst)
    (ext_reset || por_reset) |=> !cur_ff.guard_flag)
    else $error("flag kept over hardware reset");

  // The reset request is a single-cycle pulse
  // because the counter wraps to zero as the request is raised
  a_req_one_cycle: assert property (@(posedge mclk) disable iff (rst)
    chip_reset_req |=> !chip_reset_req)
    else $error("reset request too long");

  // An unlocked control write takes both fields
  // exactly as written
  a_open_write: assert property (@(posedge mclk) disable iff (rst)
    (wr_control && !ext_reset && !por_reset && !chip_reset_req)
      |=> cur_ff.divider == $past(sfr_wdata[3:0])
      && cur_ff.enable == $past(sfr_wdata[enable_bit_pos])) else $error("open write lost");

  // Each accepted control write closes the lock
  // so a second write needs a new key sequence
  a_write_relocks: assert property (@(posedge mclk) disable iff (rst)
    wr_control |=> cur_ff.key_state == key_idle)
    else $error("lock left open");

  // Read data is zero outside a read
  // so stale values never reach the bus
  a_read_idle_zero: assert property (@(posedge mclk) disable iff (rst)
    !sfr_rd |=> sfr_rdata == 8'h00)
    else $error("read data without read");

  // Control read shows enable at bit 5, divider at 3:0
  // and zero in the unused bits
  a_control_read: assert property (@(posedge mclk) disable iff (rst)
    (sfr_rd && sfr_addr == guard_control_addr) |=> sfr_rdata[7:6] == 2'b00
      && sfr_rdata[4] == 1'b0 && sfr_rdata[enable_bit_pos] == $past(cur_ff.enable)
      && sfr_rdata[3:0] == $past(cur_ff.divider)) else $error("control read wrong");

  // The inhibit option is caught at every hardware reset
  // and held until the next chip reset, guard timeout included
  a_inhibit_sampled: assert property (@(posedge mclk) disable iff (rst)
    (ext_reset || por_reset) |=> cur_ff.inhibit == $past(guard_inhibit_option))
    else $error("option not sampled");

  // An idle guard holds its counter at zero
  // so counting starts from the beginning
  a_idle_count_zero: assert property (@(posedge mclk) disable iff (rst)
    !cur_ff.running |-> cur_ff.count == '0)
    else $error("idle counter not zero");

  // The prescaler advances by one on each RC tick
  // which sets the divided clock period
  a_prescale_step: assert property (@(posedge mclk) disable iff (rst)
    rc_tick |=> cur_ff.prescale == $past(cur_ff.prescale) + prescale_width'(1))
    else $error("prescaler step wrong");

  // The RC sampler shifts one stage per system clock
  // so the edge detector sees settled stages only
  a_sync_shift: assert property (@(posedge mclk) disable iff (rst)
    1'b1 |=> cur_ff.rc_sync[2:1] == $past(cur_ff.rc_sync[1:0]))
    else $error("sampler did not shift");
endmodule : timeout_guard

// >>> tb/timeout_guard_tb.sv
// Self-checking bench for the timeout guard block
`timescale 1ns/1ps
module timeout_guard_tb;
  import guard_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic       mclk = 1'b0;   // System clock
  logic       rst = 1'b1;    // Block reset
  logic       ext_reset = 1'b0;
  logic       por_reset = 1'b0;
  logic       rc_clk = 1'b0; // Slow oscillator, eight system cycles a period
  logic       inhibit = 1'b1;
  logic       sfr_wr = 1'b0;
  logic       sfr_rd = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic       chip_reset_req;
  int         n_mismatch = 0;
  int         total_checks = 0;
  int         n;             // Cycles until a reset request
  always #4 mclk = ~mclk;
  // Oscillator stepped off the falling edge, unrelated to the access timing
  always begin
    repeat (4) @(negedge mclk);
    rc_clk <= ~rc_clk;
  end
  timeout_guard DUT (.mclk(mclk), .rst(rst), .ext_reset(ext_reset), .por_reset(por_reset),
    .rc_clk(rc_clk), .guard_inhibit_option(inhibit), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .chip_reset_req(chip_reset_req));
  // ----------------------------------------
  // Helper tasks
  // ----------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfr_wr = 1'b1; sfr_addr = a; sfr_wdata = d;
    @(negedge mclk);
    sfr_wr = 1'b0;
  endtask : wr
  // Read, data stands in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(negedge mclk);
    sfr_rd = 1'b1; sfr_addr = a;
    @(negedge mclk);
    sfr_rd = 1'b0;
    chk(name, sfr_rdata, exp);
  endtask : rd
  task automatic unlock();
    wr(timed_access_addr, unlock_key_one);
    wr(timed_access_addr, unlock_key_two);
    wr(timed_access_addr, unlock_key_three);
  endtask : unlock
  // Bounded wait for the reset request pulse; n equals lim when none came
  task automatic wait_req(input int lim, output int cnt);
    for (cnt = 0; cnt < lim; cnt++) begin
      @(negedge mclk);
      if (chip_reset_req === 1'b1) break;
    end
  endtask : wait_req
  // One-cycle external or power-on reset, samples the option bit
  task automatic hw_reset(input logic opt, input logic por);
    @(negedge mclk);
    inhibit = opt; ext_reset = ~por; por_reset = por;
    @(negedge mclk);
    ext_reset = 1'b0; por_reset = 1'b0;
  endtask : hw_reset
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    hw_reset(1'b0, 1'b0);
    rd(guard_control_addr, 8'h04, "control");
    rd(reset_cause_addr, 8'h00, "cause");
    rd(guard_refresh_addr, 8'h00, "refresh");
    rd(8'h10, 8'h00, "unmapped");
    wr(guard_control_addr, 8'h20);
    rd(guard_control_addr, 8'h04, "locked");
    unlock();
    wr(guard_control_addr, 8'h20);
    rd(guard_control_addr, 8'h20, "enabled");
    wr(guard_control_addr, 8'h04);
    rd(guard_control_addr, 8'h20, "relock");
    // Refresh well inside the 2048-cycle timeout, so no request comes
    repeat (3) begin
      wait_req(1500, n);
      chk("refreshed", 8'(n == 1500), 8'h01);
      wr(guard_refresh_addr, refresh_key_val);
    end
    wait_req(2300, n);
    chk("timeout0", 8'(n >= 2030 && n <= 2080), 8'h01);
    rd(reset_cause_addr, 8'h08, "flag");
    rd(guard_control_addr, 8'h04, "after");
    wr(reset_cause_addr, 8'h00);
    rd(reset_cause_addr, 8'h00, "sw clear");
    // Divide by two doubles the timeout
    unlock();
    wr(guard_control_addr, 8'h21);
    wait_req(4400, n);
    chk("timeout1", 8'(n >= 4070 && n <= 4130), 8'h01);
    hw_reset(1'b0, 1'b0);
    rd(reset_cause_addr, 8'h00, "ext clear");
    // Inhibit option set at power-on keeps the guard idle
    hw_reset(1'b1, 1'b1);
    unlock();
    wr(guard_control_addr, 8'h20);
    wait_req(2600, n);
    chk("inhibit", 8'(n == 2600), 8'h01);
    conclude();
  end
endmodule : timeout_guard_tb
